/* File: design/qbe_pkg.sv */
package qbe_pkg;
    localparam int LANE_W          = 9;
    localparam int WORD_W          = 18;
    localparam int ECC_W           = 5;
    localparam int CODE_W          = 23;
    localparam int DATA_W          = 18;
    localparam int ADDR_W          = 21;
    localparam int ZQ_SETUP_CYCLES = 163840;
    localparam int DLL_LOCK_CYCLES = 65536;
    localparam int ZQ_EVAL_CYCLES  = 1024;
    localparam int DRIVE_W         = 5;
    localparam logic [4:0] DRIVE_RESET = 5'h10;
    localparam int LINK_HALF_CYCLES = 8;

    typedef enum logic [1:0] {
        QBE_RD_IDLE  = 2'b00,
        QBE_RD_BEAT1 = 2'b01,
        QBE_RD_BEAT2 = 2'b10
    } qbe_rd_state_t;

    typedef enum logic [1:0] {
        QBE_C_START = 2'b00,
        QBE_C_RUN   = 2'b01
    } qbe_ctl_state_t;
endpackage

/* File: design/qbe_if.sv */
`timescale 1ns/1ps
interface qbe_if #(
    parameter int DW = qbe_pkg::DATA_W,
    parameter int AW = qbe_pkg::ADDR_W
);
    logic            k;
    logic            k_n;
    logic            c;
    logic            c_n;
    logic            read_n;
    logic            write_n;
    logic [AW-1:0]   sync_addr_in;
    logic [DW-1:0]   write_data_in;
    logic [DW/9-1:0] byte_mask_n;
    logic [DW-1:0]   read_data_out;
    logic            echo_clock_out;
    logic            dll_off_n;
    logic            impedance_ref_pin;

    modport dev (
        input  k, k_n, c, c_n, read_n, write_n, sync_addr_in, write_data_in,
        input  byte_mask_n, dll_off_n, impedance_ref_pin,
        output read_data_out, echo_clock_out
    );
    modport ctl (
        output k, k_n, c, c_n, read_n, write_n, sync_addr_in, write_data_in,
        output byte_mask_n, dll_off_n, impedance_ref_pin,
        input  read_data_out, echo_clock_out
    );
endinterface

/* File: design/qbe_device.sv */
`timescale 1ns/1ps
module qbe_device #(
    parameter int DW = qbe_pkg::DATA_W,
    parameter int AW = qbe_pkg::ADDR_W,
    parameter int ZQ_EVAL = qbe_pkg::ZQ_EVAL_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         resetn,
    input  wire logic                         ce,
    qbe_if.dev                                link,
    output logic                              ecc_active,
    output logic                              dll_bypass,
    output logic [qbe_pkg::DRIVE_W-1:0]       drive_code
);
    localparam int LANES = DW / qbe_pkg::LANE_W;
    localparam int IN_W  = 8 + AW + DW + LANES;

    // all pins are in the link domain: two flops before any use
    logic [IN_W-1:0] in_meta;
    logic [IN_W-1:0] in_sync;
    logic [3:0]      clk_prev;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            in_meta  <= '0;
            in_sync  <= '0;
            clk_prev <= '0;
        end else if (ce) begin
            in_meta  <= {link.k, link.k_n, link.c, link.c_n, link.read_n, link.write_n,
                         link.dll_off_n, link.impedance_ref_pin, link.sync_addr_in,
                         link.write_data_in, link.byte_mask_n};
            in_sync  <= in_meta;
            clk_prev <= in_sync[IN_W-1 -: 4];
        end
    end

    logic [3:0]       clk_now;
    logic             rd_req_n;
    logic             wr_req_n;
    logic             dll_off_s;
    logic             zq_s;
    logic [AW-1:0]    addr_s;
    logic [DW-1:0]    data_s;
    logic [LANES-1:0] mask_s;
    assign {clk_now, rd_req_n, wr_req_n, dll_off_s, zq_s, addr_s, data_s, mask_s} = in_sync;

    logic k_rise;
    logic kn_rise;
    logic c_rise;
    logic cn_rise;
    logic use_k;
    logic fire_b1;
    logic fire_b2;
    assign k_rise  = clk_now[3] & ~clk_prev[3];
    assign kn_rise = clk_now[2] & ~clk_prev[2];
    assign c_rise  = clk_now[1] & ~clk_prev[1];
    assign cn_rise = clk_now[0] & ~clk_prev[0];
    assign use_k   = clk_now[1] & clk_now[0];
    assign fire_b1 = use_k ? kn_rise : cn_rise;
    assign fire_b2 = use_k ? k_rise : c_rise;

    function automatic logic [qbe_pkg::CODE_W-1:0] ham_enc(
        input logic [qbe_pkg::WORD_W-1:0] d);
        logic [qbe_pkg::CODE_W-1:0] cw;
        int j;
        cw = '0;
        j = 0;
        for (int p = 1; p <= qbe_pkg::CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p-1] = d[j];
                j++;
            end
        end
        for (int b = 0; b < qbe_pkg::ECC_W; b++) begin
            for (int p = 1; p <= qbe_pkg::CODE_W; p++) begin
                if ((p & (p - 1)) != 0 && ((p >> b) & 1) == 1) begin
                    cw[(1 << b) - 1] = cw[(1 << b) - 1] ^ cw[p-1];
                end
            end
        end
        return cw;
    endfunction

    // double errors alias to a wrong flip or none; nothing flags them
    function automatic logic [qbe_pkg::WORD_W-1:0] ham_dec(
        input logic [qbe_pkg::CODE_W-1:0] cw,
        input logic                        en);
        logic [qbe_pkg::CODE_W-1:0] fx;
        logic [qbe_pkg::ECC_W-1:0]  syn;
        logic [qbe_pkg::WORD_W-1:0] d;
        int j;
        syn = '0;
        d = '0;
        j = 0;
        for (int p = 1; p <= qbe_pkg::CODE_W; p++) begin
            if (cw[p-1]) begin
                syn = syn ^ qbe_pkg::ECC_W'(p);
            end
        end
        fx = cw;
        if (en && syn != '0 && int'(syn) <= qbe_pkg::CODE_W) begin
            fx[syn-1] = ~fx[syn-1];
        end
        for (int p = 1; p <= qbe_pkg::CODE_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[j] = fx[p-1];
                j++;
            end
        end
        return d;
    endfunction

    // write port capture
    logic             wr_pend;
    logic [DW-1:0]    wr_beat1;
    logic [LANES-1:0] wr_mask1;
    logic             next_wr_pend;
    logic [DW-1:0]    next_wr_beat1;
    logic [LANES-1:0] next_wr_mask1;
    logic             ecc_off;
    logic             next_ecc_off;
    logic             commit;
    logic [LANES-1:0] half_write;

    assign commit = wr_pend & kn_rise;

    always_comb begin
        next_wr_pend  = wr_pend;
        next_wr_beat1 = wr_beat1;
        next_wr_mask1 = wr_mask1;
        next_ecc_off  = ecc_off;
        if (kn_rise) begin
            next_wr_pend = 1'b0;
        end
        if (k_rise) begin
            next_wr_pend  = ~wr_req_n;
            next_wr_beat1 = data_s;
            next_wr_mask1 = mask_s;
        end
        if (commit && half_write != '0) begin
            next_ecc_off = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_pend  <= 1'b0;
            wr_beat1 <= '0;
            wr_mask1 <= '1;
            ecc_off  <= 1'b0;
        end else if (ce) begin
            wr_pend  <= next_wr_pend;
            wr_beat1 <= next_wr_beat1;
            wr_mask1 <= next_wr_mask1;
            ecc_off  <= next_ecc_off;
        end
    end

    // per lane storage, merge and read decode
    logic [2*DW-1:0] rd_word;
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [qbe_pkg::CODE_W-1:0] mem [2**AW];
        logic [qbe_pkg::WORD_W-1:0] old_w;
        logic [qbe_pkg::WORD_W-1:0] new_w;
        logic [qbe_pkg::WORD_W-1:0] rd_w;
        logic                       we;
        assign old_w = ham_dec(mem[addr_s], ~ecc_off);
        // beat one in the low half, beat two in the high half
        assign new_w[8:0]  = wr_mask1[l] ? old_w[8:0] : wr_beat1[9*l +: 9];
        assign new_w[17:9] = mask_s[l] ? old_w[17:9] : data_s[9*l +: 9];
        assign we = commit & ~(wr_mask1[l] & mask_s[l]);
        assign half_write[l] = wr_mask1[l] ^ mask_s[l];
        always_ff @(posedge clock) begin
            if (ce && resetn && we) begin
                mem[addr_s] <= ham_enc(new_w);
            end
        end
        assign rd_w = ham_dec(mem[addr_s], ~ecc_off);
        assign rd_word[9*l +: 9]      = rd_w[8:0];
        assign rd_word[DW + 9*l +: 9] = rd_w[17:9];
    end

    // read port pipeline
    qbe_pkg::qbe_rd_state_t rd_state;
    qbe_pkg::qbe_rd_state_t next_rd_state;
    logic            rd_pend;
    logic [2*DW-1:0] rd_pend_word;
    logic [2*DW-1:0] rd_out_word;
    logic [DW-1:0]   q_reg;
    logic            echo;
    logic            next_rd_pend;
    logic [2*DW-1:0] next_rd_pend_word;
    logic [2*DW-1:0] next_rd_out_word;
    logic [DW-1:0]   next_q;
    logic            next_echo;

    always_comb begin
        next_rd_state     = rd_state;
        next_rd_pend      = rd_pend;
        next_rd_pend_word = rd_pend_word;
        next_rd_out_word  = rd_out_word;
        next_q            = q_reg;
        next_echo         = echo;
        if (fire_b1) begin
            next_echo = 1'b0;
        end
        if (fire_b2) begin
            next_echo = 1'b1;
        end
        if (fire_b1 && rd_state == qbe_pkg::QBE_RD_BEAT1) begin
            next_q        = rd_out_word[DW-1:0];
            next_rd_state = qbe_pkg::QBE_RD_BEAT2;
        end
        // second beat leaves on the same k rise that lets a new read claim the output stage; the claim below wins the state
        if (fire_b2 && rd_state == qbe_pkg::QBE_RD_BEAT2) begin
            next_q        = rd_out_word[2*DW-1:DW];
            next_rd_state = qbe_pkg::QBE_RD_IDLE;
        end
        if (k_rise) begin
            if (rd_pend) begin
                next_rd_out_word = rd_pend_word;
                next_rd_state    = qbe_pkg::QBE_RD_BEAT1;
            end
            next_rd_pend      = ~rd_req_n;
            next_rd_pend_word = rd_word;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            rd_state     <= qbe_pkg::QBE_RD_IDLE;
            rd_pend      <= 1'b0;
            rd_pend_word <= '0;
            rd_out_word  <= '0;
            q_reg        <= '0;
            echo         <= 1'b0;
        end else if (ce) begin
            rd_state     <= next_rd_state;
            rd_pend      <= next_rd_pend;
            rd_pend_word <= next_rd_pend_word;
            rd_out_word  <= next_rd_out_word;
            q_reg        <= next_q;
            echo         <= next_echo;
        end
    end

    // impedance tracking and dll mode
    logic [$clog2(ZQ_EVAL)-1:0] zq_cnt;
    logic [$clog2(ZQ_EVAL)-1:0] next_zq_cnt;
    logic [qbe_pkg::DRIVE_W-1:0] next_drive;
    logic                        next_bypass;

    always_comb begin
        next_zq_cnt = zq_cnt + 1'b1;
        next_drive  = drive_code;
        next_bypass = ~dll_off_s;
        if (int'(zq_cnt) == ZQ_EVAL - 1) begin
            next_zq_cnt = '0;
            // zq high: driver too weak, step stronger
            if (zq_s && drive_code != '1) begin
                next_drive = drive_code + 1'b1;
            end else if (!zq_s && drive_code != '0) begin
                next_drive = drive_code - 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            zq_cnt     <= '0;
            drive_code <= qbe_pkg::DRIVE_RESET;
            dll_bypass <= 1'b0;
            ecc_active <= 1'b1;
        end else if (ce) begin
            zq_cnt     <= next_zq_cnt;
            drive_code <= next_drive;
            dll_bypass <= next_bypass;
            ecc_active <= ~next_ecc_off;
        end
    end

    assign link.read_data_out  = q_reg;
    assign link.echo_clock_out = echo;
endmodule

/* File: design/qbe_controller.sv */
`timescale 1ns/1ps
module qbe_controller #(
    parameter int DW = qbe_pkg::DATA_W,
    parameter int AW = qbe_pkg::ADDR_W,
    parameter int HALF = qbe_pkg::LINK_HALF_CYCLES,
    parameter int ZQ_SETUP = qbe_pkg::ZQ_SETUP_CYCLES,
    parameter int DLL_LOCK = qbe_pkg::DLL_LOCK_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                ce,
    qbe_if.ctl                       link,
    input  wire logic                use_k_clocks,
    input  wire logic                dll_enable,
    input  wire logic                zq_weak,
    input  wire logic                req_valid,
    input  wire logic                req_write,
    input  wire logic [AW-1:0]       req_addr,
    input  wire logic [2*DW-1:0]     req_data,
    input  wire logic [2*DW/9-1:0]   req_mask_n,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [2*DW-1:0]          rsp_data
);
    localparam int PW    = $clog2(2 * HALF);
    localparam int SW    = $clog2(ZQ_SETUP + DLL_LOCK + 1);
    localparam int LANES = DW / 9;

    // read data comes from the device clock: two flops
    logic [DW-1:0] q_meta;
    logic [DW-1:0] q_sync;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            q_meta <= '0;
            q_sync <= '0;
        end else if (ce) begin
            q_meta <= link.read_data_out;
            q_sync <= q_meta;
        end
    end

    qbe_pkg::qbe_ctl_state_t st;
    qbe_pkg::qbe_ctl_state_t next_st;
    logic [PW-1:0]      ph;
    logic [SW-1:0]      up_cnt;
    logic               kq;
    logic               cq;
    logic               rn;
    logic               wn;
    logic               wr2;
    logic [AW-1:0]      ad;
    logic [DW-1:0]      dq;
    logic [LANES-1:0]   mq;
    logic [2*DW-1:0]    wr_keep;
    logic [LANES-1:0]   m_keep;
    logic [2:0]         rd_pipe;
    logic               issued;
    logic               dll_on;
    logic               zq_drv;
    logic [PW-1:0]      next_ph;
    logic [SW-1:0]      next_up_cnt;
    logic               next_kq;
    logic               next_cq;
    logic               next_rn;
    logic               next_wn;
    logic               next_wr2;
    logic [AW-1:0]      next_ad;
    logic [DW-1:0]      next_dq;
    logic [LANES-1:0]   next_mq;
    logic [2*DW-1:0]    next_wr_keep;
    logic [LANES-1:0]   next_m_keep;
    logic [2:0]         next_rd_pipe;
    logic               next_issued;
    logic               next_ready;
    logic               next_rsp_valid;
    logic [2*DW-1:0]    next_rsp_data;
    logic               load1;
    logic               load2;
    logic               end_per;

    // pins change mid half so each lands well before the edge that samples it
    assign load1   = ph == PW'(HALF + HALF / 2);
    assign load2   = ph == PW'(HALF / 2);
    assign end_per = ph == PW'(2 * HALF - 1);

    always_comb begin
        next_st        = st;
        next_ph        = end_per ? '0 : ph + 1'b1;
        next_kq        = next_ph < PW'(HALF);
        next_cq        = next_kq;
        next_up_cnt    = up_cnt;
        next_rn        = rn;
        next_wn        = wn;
        next_wr2       = wr2;
        next_ad        = ad;
        next_dq        = dq;
        next_mq        = mq;
        next_wr_keep   = wr_keep;
        next_m_keep    = m_keep;
        next_rd_pipe   = rd_pipe;
        next_issued    = issued;
        next_rsp_valid = 1'b0;
        next_rsp_data  = rsp_data;
        next_ready     = 1'b0;
        if (st == qbe_pkg::QBE_C_START) begin
            // impedance setup, then dll lock, counted in k periods
            if (end_per && dll_on) begin
                next_up_cnt = up_cnt + 1'b1;
            end
            if (int'(up_cnt) >= ZQ_SETUP + DLL_LOCK) begin
                next_st = qbe_pkg::QBE_C_RUN;
            end
        end else begin
            next_ready = ph == PW'(HALF + HALF / 2 - 1);
            if (load1) begin
                next_rn     = 1'b1;
                next_wn     = 1'b1;
                next_issued = 1'b0;
                if (req_valid && req_ready) begin
                    next_ad = req_addr;
                    if (req_write) begin
                        next_wn      = 1'b0;
                        next_dq      = req_data[DW-1:0];
                        next_mq      = req_mask_n[LANES-1:0];
                        next_wr_keep = req_data;
                        next_m_keep  = req_mask_n[2*LANES-1:LANES];
                        next_wr2     = 1'b1;
                    end else begin
                        next_rn     = 1'b0;
                        next_issued = 1'b1;
                    end
                end
            end
            if (load2 && wr2) begin
                next_dq  = wr_keep[2*DW-1:DW];
                next_mq  = m_keep;
                next_wr2 = 1'b0;
            end
            if (end_per) begin
                if (rd_pipe[1]) begin
                    next_rsp_data[DW-1:0] = q_sync;
                end
                next_rd_pipe = {rd_pipe[1:0], issued};
            end
            if (ph == PW'(HALF - 1) && rd_pipe[2]) begin
                next_rsp_data[2*DW-1:DW] = q_sync;
                next_rsp_valid           = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st <= qbe_pkg::QBE_C_START;
            ph <= '0;
            up_cnt <= '0;
            kq <= 1'b1;
            cq <= 1'b1;
            rn <= 1'b1;
            wn <= 1'b1;
            wr2 <= 1'b0;
            ad <= '0;
            dq <= '0;
            mq <= '1;
            wr_keep <= '0;
            m_keep <= '1;
            rd_pipe <= '0;
            issued <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            dll_on <= 1'b0;
            zq_drv <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            ph <= next_ph;
            up_cnt <= next_up_cnt;
            kq <= next_kq;
            cq <= use_k_clocks ? 1'b1 : next_cq;
            rn <= next_rn;
            wn <= next_wn;
            wr2 <= next_wr2;
            ad <= next_ad;
            dq <= next_dq;
            mq <= next_mq;
            wr_keep <= next_wr_keep;
            m_keep <= next_m_keep;
            rd_pipe <= next_rd_pipe;
            issued <= next_issued;
            req_ready <= next_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            dll_on <= dll_enable;
            zq_drv <= zq_weak;
        end
    end

    assign link.k                 = kq;
    assign link.k_n               = ~kq;
    assign link.c                 = cq;
    assign link.c_n               = use_k_clocks ? 1'b1 : ~cq;
    assign link.read_n            = rn;
    assign link.write_n           = wn;
    assign link.sync_addr_in      = ad;
    assign link.write_data_in     = dq;
    assign link.byte_mask_n       = mq;
    assign link.dll_off_n         = dll_on;
    assign link.impedance_ref_pin = zq_drv;
endmodule

/* File: bench/qbe_checker.sv */
`timescale 1ns/1ps
module qbe_checker #(
    parameter int DW      = 18,
    parameter int AW      = 21,
    parameter int STARTUP = 8
) (
    input  wire logic            clock,
    input  wire logic            resetn,
    input  wire logic            ce,
    input  wire logic            k,
    input  wire logic            k_n,
    input  wire logic            c,
    input  wire logic            c_n,
    input  wire logic            read_n,
    input  wire logic            write_n,
    input  wire logic [AW-1:0]   sync_addr_in,
    input  wire logic [DW-1:0]   write_data_in,
    input  wire logic [DW/9-1:0] byte_mask_n,
    input  wire logic [DW-1:0]   read_data_out,
    input  wire logic            echo_clock_out
);
    logic        k_q;
    logic [15:0] k_rises;

    default clocking cb @(posedge clock); endclocking
    // frozen cycles stretch every phase, so timing checks pause with the clock enable
    default disable iff (!resetn || !ce);

    // saturating, so a long run never wraps back under the start-up bound
    always_ff @(posedge clock) begin
        if (!resetn) begin
            k_q <= 1'b1;
            k_rises <= 16'h0;
        end else begin
            k_q <= k;
            if (k && !k_q && k_rises != 16'hffff) begin
                k_rises <= k_rises + 16'h1;
            end
        end
    end

    // k high phase is eight device cycles at the default half period
    sequence k_high_run;
        k [*8] ##1 !k;
    endsequence

    chk_kn_inverse: assert property (k_n == ~k)
        else $error("k_n is not the inverse of k");
    chk_k_high_phase: assert property ($rose(k) |-> k_high_run)
        else $error("k high phase has the wrong length");
    chk_out_clk_pair: assert property ((c_n == ~c) || (c && c_n))
        else $error("output clock pair is neither inverse nor both high");
    chk_read_pins_settled: assert property ($rose(k) |-> read_n == $past(read_n, 3)
        && sync_addr_in == $past(sync_addr_in, 3))
        else $error("read request or address moved just before k rise");
    chk_beat1_settled: assert property ($rose(k) |-> write_n == $past(write_n, 3)
        && write_data_in == $past(write_data_in, 3)
        && byte_mask_n == $past(byte_mask_n, 3))
        else $error("write request or first beat moved just before k rise");
    chk_beat2_settled: assert property ($rose(k_n) |-> sync_addr_in == $past(sync_addr_in, 3)
        && write_data_in == $past(write_data_in, 3)
        && byte_mask_n == $past(byte_mask_n, 3))
        else $error("write address, second beat or mask moved before k_n rise");
    chk_startup_quiet: assert property ((!read_n || !write_n) |-> k_rises >= STARTUP)
        else $error("access issued before the start-up wait ran out");
    chk_data_with_echo: assert property (!$stable(read_data_out) |-> !$stable(echo_clock_out))
        else $error("read data changed away from an echo clock edge");
endmodule

/* File: bench/test_qdr_burst2_ecc_sram_port.sv */
`timescale 1ns/1ps
module test_qdr_burst2_ecc_sram_port;
    localparam int AW = 6;
    localparam int DW = 18;
    logic          clock, resetn, ce, dll_en, use_k, zq_weak, req_valid, req_write;
    logic          req_ready, rsp_valid, ecc_active, dll_bypass;
    logic [AW-1:0] req_addr;
    logic [35:0]   req_data, rsp_data, exp_word;
    logic [3:0]    req_mask_n;
    logic [4:0]    drive_code, last_drive;
    logic [35:0]   pat [4] = '{36'h123456789, 36'hfedcba987, 36'h0f0f0f0f0, 36'h5a5a5a5a5};
    logic [3:0]    msk [4] = '{4'h0, 4'h5, 4'h4, 4'h2};
    int            n_fail, tests_run, cycles;

    qbe_if #(.DW(DW), .AW(AW)) link ();
    qbe_device #(.DW(DW), .AW(AW), .ZQ_EVAL(16)) u_qbe_device (.clock(clock), .resetn(resetn),
        .ce(ce), .link(link), .ecc_active(ecc_active), .dll_bypass(dll_bypass),
        .drive_code(drive_code));
    // start-up counts shortened so the run stays brief
    qbe_controller #(.DW(DW), .AW(AW), .ZQ_SETUP(4), .DLL_LOCK(4)) u_qbe_controller (
        .clock(clock), .resetn(resetn), .ce(ce), .link(link), .use_k_clocks(use_k),
        .dll_enable(dll_en), .zq_weak(zq_weak), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_data(req_data), .req_mask_n(req_mask_n),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    // one period of slack for where the start-up count begins
    qbe_checker #(.DW(DW), .AW(AW), .STARTUP(7)) u_qbe_checker (.clock(clock), .resetn(resetn),
        .ce(ce), .k(link.k), .k_n(link.k_n), .c(link.c), .c_n(link.c_n),
        .read_n(link.read_n), .write_n(link.write_n), .sync_addr_in(link.sync_addr_in),
        .write_data_in(link.write_data_in), .byte_mask_n(link.byte_mask_n),
        .read_data_out(link.read_data_out), .echo_clock_out(link.echo_clock_out));

    always #2.5 clock = ~clock;

    task stop_test;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task check(input logic [35:0] got, input logic [35:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // valid held until the edge that samples the ready pulse
    task access(input logic wr, input logic [AW-1:0] a, input logic [35:0] d,
                input logic [3:0] m);
        int i;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_data = d;
        req_mask_n = m;
        i = 0;
        while (req_ready !== 1'b1 && i < 2000) begin
            @(negedge clock);
            i++;
        end
        @(negedge clock);
        req_valid = 1'b0;
        @(negedge clock);
    endtask

    task read_check(input logic [AW-1:0] a, input logic [35:0] exp);
        int i;
        access(1'b0, a, 36'h0, 4'h0);
        i = 0;
        while (rsp_valid !== 1'b1 && i < 2000) begin
            @(negedge clock);
            i++;
        end
        check(rsp_data, exp);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            stop_test();
        end
    end

    always @(negedge clock) begin
        if (cycles > 10 && drive_code !== last_drive) begin
            check(36'(drive_code - last_drive == 5'h1 || last_drive - drive_code == 5'h1), 36'h1);
        end
        last_drive = drive_code;
    end

    initial begin
        clock = 0; resetn = 0; use_k = 0; zq_weak = 0; req_valid = 0; req_write = 0;
        req_addr = '0; req_data = '0; req_mask_n = '0; n_fail = 0; tests_run = 0;
        cycles = 0; last_drive = 5'h10;
        ce = 1'b1;
        dll_en = 1'b1;
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        access(1'b1, 6'h15, pat[3], 4'h0);
        check({35'h0, dll_bypass}, 36'h0);
        dll_en = 1'b0;
        repeat (8) @(negedge clock);
        check({35'h0, dll_bypass}, 36'h1);
        dll_en = 1'b1;
        exp_word = 36'h0;
        for (int s = 0; s < 4; s++) begin
            access(1'b1, 6'h2a, pat[s], msk[s]);
            for (int b = 0; b < 2; b++) begin
                for (int l = 0; l < 2; l++) begin
                    if (!msk[s][b*2+l]) exp_word[b*18+l*9 +: 9] = pat[s][b*18+l*9 +: 9];
                end
            end
            repeat (40) @(negedge clock);
            read_check(6'h2a, exp_word);
            if (s == 1) check({35'h0, ecc_active}, 36'h1);
        end
        check({35'h0, ecc_active}, 36'h0);
        use_k = 1'b1;
        read_check(6'h15, pat[3]);
        use_k = 1'b0;
        // zq low all run long: the setting has stepped down to its floor
        check({31'h0, drive_code}, 36'h0);
        zq_weak = 1'b1;
        repeat (400) @(negedge clock);
        check({35'h0, drive_code > 5'h10}, 36'h1);
        // frozen, the evaluation counter must not step the setting
        ce = 1'b0;
        exp_word = {31'h0, drive_code};
        repeat (40) @(negedge clock);
        check({31'h0, drive_code}, exp_word);
        ce = 1'b1;
        stop_test();
    end
endmodule
